// ---- pkg/handler_io_consts.svh ----
// register map, field positions, reset values for the handler i/o ports
`ifndef HANDLER_IO_CONSTS_SVH
`define HANDLER_IO_CONSTS_SVH

// ==========================================================
// bus geometry
`define HIO_ADDR_W        8
`define HIO_DATA_W        32

// ==========================================================
// register byte offsets
`define HIO_OFS_BYTE_LO   8'h00
`define HIO_OFS_BYTE_HI   8'h04
`define HIO_OFS_HALFWORD  8'h08
`define HIO_OFS_NIB_LO    8'h0c
`define HIO_OFS_NIB_HI    8'h10
`define HIO_OFS_NIB_BOTH  8'h14
`define HIO_OFS_CTRL      8'h18
`define HIO_OFS_SINGLE    8'h1c

// ==========================================================
// control register fields
`define HIO_CTRL_LO_DIR   0
`define HIO_CTRL_HI_DIR   1
`define HIO_CTRL_IDX_EN   2
`define HIO_CTRL_TRG_EN   3

// single output register fields
`define HIO_SOUT_ONE      0
`define HIO_SOUT_TWO      1

// positions taken over in the upper byte
`define HIO_HI_IDX_BIT    6
`define HIO_HI_TRG_BIT    7

// ==========================================================
// reset values
`define HIO_RST_BYTE      8'h00
`define HIO_RST_NIB       4'h0
`define HIO_RST_EN        1'b0
`define HIO_RST_SOUT      1'b0

`endif

// ---- pkg/handler_io_pkg.sv ----
// types shared by the handler i/o port logic
package handler_io_pkg;

  // ========================================================
  // nibble port direction
  typedef enum logic {
    DIR_INPUT  = 1'b0,
    DIR_OUTPUT = 1'b1
  } port_dir_t;

  // ========================================================
  // axi4-lite response codes used by the slave
  typedef enum logic [1:0] {
    RESP_OKAY   = 2'b00,
    RESP_SLVERR = 2'b10
  } axi_resp_t;

endpackage

// ---- rtl/pin_sync.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps

module pin_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ========================================================
  // stages
  logic [WIDTH-1:0] stage1_q;  // first stage, read only by stage 2
  logic [WIDTH-1:0] stage1_d;  // next first stage
  logic [WIDTH-1:0] stage2_q;  // safe synchronised value
  logic [WIDTH-1:0] stage2_d;  // next second stage

  // next values of both stages
  always_comb begin
    stage1_d = async_in;
    stage2_d = stage1_q;
  end

  // registers only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= stage1_d;
      stage2_q <= stage2_d;
    end
  end

  assign sync_out = stage2_q;

endmodule

// ---- rtl/handler_io_ports.sv ----
// handler i/o ports: output bytes, nibble ports, strobes, axi4-lite slave
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "handler_io_consts.svh"

module handler_io_ports (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // axi4-lite write address
  input  wire logic [`HIO_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]             s_axi_awprot,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  // axi4-lite write data
  input  wire logic [`HIO_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // axi4-lite read address
  input  wire logic [`HIO_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]             s_axi_arprot,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  // axi4-lite read data
  output logic [`HIO_DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // strobes from the measurement sequencer, same clock
  input  wire logic                   sort_index_strobe,
  input  wire logic                   trigger_ready_flag,
  // output-only bytes toward the handler
  output logic [7:0]                  out_byte_lo,
  output logic [7:0]                  out_byte_hi,
  // lower nibble port, two-way
  input  wire logic [3:0]             nibble_lo_in,
  output logic [3:0]                  nibble_lo_out,
  output logic [3:0]                  nibble_lo_oe,
  // upper nibble port, two-way
  input  wire logic [3:0]             nibble_hi_in,
  output logic [3:0]                  nibble_hi_out,
  output logic [3:0]                  nibble_hi_oe,
  // single-bit output terminals
  output logic                        single_out_terminal_one,
  output logic                        single_out_terminal_two
);

  // ========================================================
  // helper functions

  // merge a write into the upper byte, keeping taken-over bits
  function automatic logic [7:0] merge_hi(
    input logic [7:0] old_val,
    input logic [7:0] new_val,
    input logic       idx_en,
    input logic       trg_en
  );
    logic [7:0] res;
    res = new_val;
    if (idx_en) begin
      res[`HIO_HI_IDX_BIT] = old_val[`HIO_HI_IDX_BIT];
    end
    if (trg_en) begin
      res[`HIO_HI_TRG_BIT] = old_val[`HIO_HI_TRG_BIT];
    end
    return res;
  endfunction

  // value a nibble returns on read, by its direction
  function automatic logic [3:0] nib_view(
    input handler_io_pkg::port_dir_t dir,
    input logic [3:0]                latch,
    input logic [3:0]                pins
  );
    if (dir == handler_io_pkg::DIR_OUTPUT) begin
      return latch;
    end else begin
      return pins;
    end
  endfunction

  // true for every mapped word address
  function automatic logic addr_ok(input logic [`HIO_ADDR_W-1:0] a);
    case (a)
      `HIO_OFS_BYTE_LO, `HIO_OFS_BYTE_HI, `HIO_OFS_HALFWORD,
      `HIO_OFS_NIB_LO, `HIO_OFS_NIB_HI, `HIO_OFS_NIB_BOTH,
      `HIO_OFS_CTRL, `HIO_OFS_SINGLE: begin
        return 1'b1;
      end
      default: begin
        return 1'b0;
      end
    endcase
  endfunction

  // ========================================================
  // synchronised handler pins
  logic [3:0] nib_lo_pins;  // lower nibble pins after two flops
  logic [3:0] nib_hi_pins;  // upper nibble pins after two flops

  pin_sync #(
    .WIDTH (4)
  ) u_sync_lo (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (nibble_lo_in),
    .sync_out (nib_lo_pins)
  );

  pin_sync #(
    .WIDTH (4)
  ) u_sync_hi (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (nibble_hi_in),
    .sync_out (nib_hi_pins)
  );

  // ========================================================
  // axi write channel state
  logic                   aw_full_q, aw_full_d;  // address held
  logic                   w_full_q, w_full_d;    // data held
  logic [`HIO_ADDR_W-1:0] aw_addr_q, aw_addr_d;  // held address
  logic [`HIO_DATA_W-1:0] w_data_q, w_data_d;    // held data
  logic [3:0]             w_strb_q, w_strb_d;    // held strobes
  logic                   awready_q, awready_d;  // address ready
  logic                   wready_q, wready_d;    // data ready
  logic                   bvalid_q, bvalid_d;    // response valid
  logic [1:0]             bresp_q, bresp_d;      // response code
  logic                   do_write;              // commit this cycle

  // accept address and data in either order, answer after both
  always_comb begin
    aw_full_d = aw_full_q;
    w_full_d  = w_full_q;
    aw_addr_d = aw_addr_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    do_write  = aw_full_q && w_full_q && !bvalid_q;
    // address handshake
    if (s_axi_awvalid && awready_q) begin
      aw_full_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    // data handshake
    if (s_axi_wvalid && wready_q) begin
      w_full_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    // commit and raise response
    if (do_write) begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = addr_ok(aw_addr_q) ? handler_io_pkg::RESP_OKAY
                                     : handler_io_pkg::RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    // ready only while the slot is free and no answer pending
    awready_d = !aw_full_d && !bvalid_d;
    wready_d  = !w_full_d && !bvalid_d;
  end

  // write channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= handler_io_pkg::RESP_OKAY;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      aw_addr_q <= aw_addr_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
    end
  end

  // ========================================================
  // software-visible port registers
  logic [7:0]                byte_lo_q, byte_lo_d;  // lower byte data
  logic [7:0]                byte_hi_q, byte_hi_d;  // upper byte data
  logic [3:0]                nib_lo_q, nib_lo_d;    // lower nibble latch
  logic [3:0]                nib_hi_q, nib_hi_d;    // upper nibble latch
  handler_io_pkg::port_dir_t lo_dir_q, lo_dir_d;    // lower direction
  handler_io_pkg::port_dir_t hi_dir_q, hi_dir_d;    // upper direction
  logic                      idx_en_q, idx_en_d;    // index strobe on
  logic                      trg_en_q, trg_en_d;    // ready flag on
  logic                      sout1_q, sout1_d;      // terminal one
  logic                      sout2_q, sout2_d;      // terminal two

  // register updates on a committed write
  always_comb begin
    byte_lo_d = byte_lo_q;
    byte_hi_d = byte_hi_q;
    nib_lo_d  = nib_lo_q;
    nib_hi_d  = nib_hi_q;
    lo_dir_d  = lo_dir_q;
    hi_dir_d  = hi_dir_q;
    idx_en_d  = idx_en_q;
    trg_en_d  = trg_en_q;
    sout1_d   = sout1_q;
    sout2_d   = sout2_q;
    if (do_write) begin
      unique case (aw_addr_q)
        `HIO_OFS_BYTE_LO: begin
          if (w_strb_q[0]) begin
            byte_lo_d = w_data_q[7:0];
          end
        end
        `HIO_OFS_BYTE_HI: begin
          if (w_strb_q[0]) begin
            byte_hi_d = merge_hi(byte_hi_q, w_data_q[7:0],
                                 idx_en_q, trg_en_q);
          end
        end
        `HIO_OFS_HALFWORD: begin
          if (w_strb_q[0]) begin
            byte_lo_d = w_data_q[7:0];
          end
          if (w_strb_q[1]) begin
            byte_hi_d = merge_hi(byte_hi_q, w_data_q[15:8],
                                 idx_en_q, trg_en_q);
          end
        end
        `HIO_OFS_NIB_LO: begin
          if (w_strb_q[0]) begin
            nib_lo_d = w_data_q[3:0];
          end
        end
        `HIO_OFS_NIB_HI: begin
          if (w_strb_q[0]) begin
            nib_hi_d = w_data_q[3:0];
          end
        end
        `HIO_OFS_NIB_BOTH: begin
          if (w_strb_q[0]) begin
            nib_lo_d = w_data_q[3:0];
            nib_hi_d = w_data_q[7:4];
          end
        end
        `HIO_OFS_CTRL: begin
          if (w_strb_q[0]) begin
            lo_dir_d = handler_io_pkg::port_dir_t'(
                         w_data_q[`HIO_CTRL_LO_DIR]);
            hi_dir_d = handler_io_pkg::port_dir_t'(
                         w_data_q[`HIO_CTRL_HI_DIR]);
            idx_en_d = w_data_q[`HIO_CTRL_IDX_EN];
            trg_en_d = w_data_q[`HIO_CTRL_TRG_EN];
          end
        end
        `HIO_OFS_SINGLE: begin
          if (w_strb_q[0]) begin
            sout1_d = w_data_q[`HIO_SOUT_ONE];
            sout2_d = w_data_q[`HIO_SOUT_TWO];
          end
        end
        default: begin
          // unmapped: nothing stored, slverr answered
          byte_lo_d = byte_lo_q;
        end
      endcase
    end
  end

  // port registers, reset to preset state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      byte_lo_q <= `HIO_RST_BYTE;
      byte_hi_q <= `HIO_RST_BYTE;
      nib_lo_q  <= `HIO_RST_NIB;
      nib_hi_q  <= `HIO_RST_NIB;
      lo_dir_q  <= handler_io_pkg::DIR_INPUT;
      hi_dir_q  <= handler_io_pkg::DIR_INPUT;
      idx_en_q  <= `HIO_RST_EN;
      trg_en_q  <= `HIO_RST_EN;
      sout1_q   <= `HIO_RST_SOUT;
      sout2_q   <= `HIO_RST_SOUT;
    end else begin
      byte_lo_q <= byte_lo_d;
      byte_hi_q <= byte_hi_d;
      nib_lo_q  <= nib_lo_d;
      nib_hi_q  <= nib_hi_d;
      lo_dir_q  <= lo_dir_d;
      hi_dir_q  <= hi_dir_d;
      idx_en_q  <= idx_en_d;
      trg_en_q  <= trg_en_d;
      sout1_q   <= sout1_d;
      sout2_q   <= sout2_d;
    end
  end

  // ========================================================
  // axi read channel
  logic                   arready_q, arready_d;  // read address ready
  logic                   rvalid_q, rvalid_d;    // read data valid
  logic [`HIO_DATA_W-1:0] rdata_q, rdata_d;      // read data
  logic [1:0]             rresp_q, rresp_d;      // read response

  // one read at a time, answered the cycle after the handshake
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d  = addr_ok(s_axi_araddr) ? handler_io_pkg::RESP_OKAY
                                       : handler_io_pkg::RESP_SLVERR;
      rdata_d  = '0;
      unique case (s_axi_araddr)
        `HIO_OFS_BYTE_LO:  rdata_d[7:0]  = byte_lo_q;
        `HIO_OFS_BYTE_HI:  rdata_d[7:0]  = byte_hi_q;
        `HIO_OFS_HALFWORD: rdata_d[15:0] = {byte_hi_q, byte_lo_q};
        `HIO_OFS_NIB_LO:   rdata_d[3:0]  = nib_view(lo_dir_q, nib_lo_q,
                                                    nib_lo_pins);
        `HIO_OFS_NIB_HI:   rdata_d[3:0]  = nib_view(hi_dir_q, nib_hi_q,
                                                    nib_hi_pins);
        `HIO_OFS_NIB_BOTH: rdata_d[7:0]  = {
                             nib_view(hi_dir_q, nib_hi_q, nib_hi_pins),
                             nib_view(lo_dir_q, nib_lo_q, nib_lo_pins)};
        `HIO_OFS_CTRL: begin
          rdata_d[`HIO_CTRL_LO_DIR] = lo_dir_q;
          rdata_d[`HIO_CTRL_HI_DIR] = hi_dir_q;
          rdata_d[`HIO_CTRL_IDX_EN] = idx_en_q;
          rdata_d[`HIO_CTRL_TRG_EN] = trg_en_q;
        end
        `HIO_OFS_SINGLE: begin
          rdata_d[`HIO_SOUT_ONE] = sout1_q;
          rdata_d[`HIO_SOUT_TWO] = sout2_q;
        end
        default: rdata_d = '0;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    arready_d = !rvalid_d;
  end

  // read channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= handler_io_pkg::RESP_OKAY;
    end else begin
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // ========================================================
  // pin drivers, all registered
  logic [7:0] pin_lo_q, pin_lo_d;      // lower byte pins
  logic [7:0] pin_hi_q, pin_hi_d;      // upper byte pins
  logic [3:0] pin_nlo_q, pin_nlo_d;    // lower nibble drive
  logic [3:0] pin_nhi_q, pin_nhi_d;    // upper nibble drive
  logic [3:0] oe_nlo_q, oe_nlo_d;      // lower nibble enables
  logic [3:0] oe_nhi_q, oe_nhi_d;      // upper nibble enables

  // compute pin values from registers and strobes
  always_comb begin
    pin_lo_d = byte_lo_q;
    pin_hi_d = byte_hi_q;
    if (idx_en_q) begin
      pin_hi_d[`HIO_HI_IDX_BIT] = sort_index_strobe;
    end
    if (trg_en_q) begin
      pin_hi_d[`HIO_HI_TRG_BIT] = trigger_ready_flag;
    end
    pin_nlo_d = nib_lo_q;
    pin_nhi_d = nib_hi_q;
    oe_nlo_d  = {4{lo_dir_q == handler_io_pkg::DIR_OUTPUT}};
    oe_nhi_d  = {4{hi_dir_q == handler_io_pkg::DIR_OUTPUT}};
  end

  // pin registers; nibbles released (input) from reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_lo_q  <= `HIO_RST_BYTE;
      pin_hi_q  <= `HIO_RST_BYTE;
      pin_nlo_q <= `HIO_RST_NIB;
      pin_nhi_q <= `HIO_RST_NIB;
      oe_nlo_q  <= 4'h0;
      oe_nhi_q  <= 4'h0;
    end else begin
      pin_lo_q  <= pin_lo_d;
      pin_hi_q  <= pin_hi_d;
      pin_nlo_q <= pin_nlo_d;
      pin_nhi_q <= pin_nhi_d;
      oe_nlo_q  <= oe_nlo_d;
      oe_nhi_q  <= oe_nhi_d;
    end
  end

  // ========================================================
  // output assignments, straight from flops
  assign s_axi_awready           = awready_q;
  assign s_axi_wready            = wready_q;
  assign s_axi_bvalid            = bvalid_q;
  assign s_axi_bresp             = bresp_q;
  assign s_axi_arready           = arready_q;
  assign s_axi_rvalid            = rvalid_q;
  assign s_axi_rdata             = rdata_q;
  assign s_axi_rresp             = rresp_q;
  assign out_byte_lo             = pin_lo_q;
  assign out_byte_hi             = pin_hi_q;
  assign nibble_lo_out           = pin_nlo_q;
  assign nibble_lo_oe            = oe_nlo_q;
  assign nibble_hi_out           = pin_nhi_q;
  assign nibble_hi_oe            = oe_nhi_q;
  assign single_out_terminal_one = sout1_q;
  assign single_out_terminal_two = sout2_q;

endmodule

// ---- tb/handler_io_monitor.sv ----
// concurrent checks on the handler i/o ports, bound to the top module
`timescale 1ns/1ps
module handler_io_monitor (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       sort_index_strobe,
  input wire logic       trigger_ready_flag,
  input wire logic [7:0] out_byte_lo,
  input wire logic [7:0] out_byte_hi,
  input wire logic [3:0] nibble_lo_oe,
  input wire logic [3:0] nibble_hi_oe
);
  // ========================================================
  // clocking and reset for every check
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // address and data taken at one edge
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // a write response is up now or was one edge ago
  sequence near_resp;
    s_axi_bvalid || $past(s_axi_bvalid);
  endsequence

  // ========================================================
  // bus timing
  chk_wr_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read data late");
  chk_aw_refuse: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken early");
  chk_r_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken early");
  // ========================================================
  // pins move only after a committed write or a strobe; each nibble enable is all on or all off
  chk_lo_steady: assert property (
    $changed(out_byte_lo) |-> near_resp) else $error("lower byte moved");
  chk_lo_oe_whole: assert property (
    nibble_lo_oe == 4'h0 || nibble_lo_oe == 4'hf)
    else $error("lower enable split");
  chk_hi_oe_whole: assert property (
    nibble_hi_oe == 4'h0 || nibble_hi_oe == 4'hf)
    else $error("upper enable split");
  chk_oe_steady: assert property (
    $changed(nibble_lo_oe) || $changed(nibble_hi_oe) |-> near_resp)
    else $error("nibble enable moved");
  chk_idx_follow: assert property (
    $changed(out_byte_hi[6]) && !s_axi_bvalid && !$past(s_axi_bvalid)
    |-> out_byte_hi[6] == $past(sort_index_strobe))
    else $error("bit 6 not the index strobe");
  chk_trg_follow: assert property (
    $changed(out_byte_hi[7]) && !s_axi_bvalid && !$past(s_axi_bvalid)
    |-> out_byte_hi[7] == $past(trigger_ready_flag))
    else $error("bit 7 not the ready flag");
endmodule

bind handler_io_ports handler_io_monitor i_handler_io_monitor (.*);

// ---- tb/handler_model.sv ----
// external handler: drives nibble pins wherever the device does not
`timescale 1ns/1ps
module handler_model (
  input wire logic [3:0] nibble_lo_out,
  input wire logic [3:0] nibble_lo_oe,
  input wire logic [3:0] nibble_hi_out,
  input wire logic [3:0] nibble_hi_oe,
  input wire logic [3:0] hnd_lo,
  input wire logic [3:0] hnd_hi,
  output logic     [3:0] nibble_lo_in,
  output logic     [3:0] nibble_hi_in
);
  assign nibble_lo_in = (nibble_lo_oe & nibble_lo_out)
                      | (~nibble_lo_oe & hnd_lo);
  assign nibble_hi_in = (nibble_hi_oe & nibble_hi_out)
                      | (~nibble_hi_oe & hnd_hi);
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the handler i/o ports
`timescale 1ns/1ps
`include "handler_io_consts.svh"
module tb_top;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        sort_index_strobe = 1'b0, trigger_ready_flag = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  out_byte_lo, out_byte_hi;
  logic [3:0]  nibble_lo_in, nibble_lo_out, nibble_lo_oe;
  logic [3:0]  nibble_hi_in, nibble_hi_out, nibble_hi_oe;
  logic [3:0]  hnd_lo = 4'h0, hnd_hi = 4'h0;
  logic        single_out_terminal_one, single_out_terminal_two;
  int          n_errors = 0;
  int          checks_done = 0;

  // 200 mhz clock
  always #2.5 aclk = ~aclk;
  handler_io_ports i_handler_io_ports (.*);
  handler_model i_handler_model (.*);

  // ========================================================
  // compare and verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ========================================================
  // axi4-lite write: offer both, release each when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check(s_axi_bresp, r);
    // let the committed value land on the pins
    @(posedge aclk);
  endtask
  // axi4-lite read with expected data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, exp);
    check(s_axi_rresp, r);
    // let an edge pass so a following read never re-drives rready at once
    @(posedge aclk);
  endtask

  // ========================================================
  // main sequence
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`HIO_OFS_CTRL, 32'h0, 2'h0);
    check(nibble_lo_oe, 4'h0);
    wr(`HIO_OFS_BYTE_LO, 32'ha5, 4'h1, 2'h0);
    check(out_byte_lo, 8'ha5);
    wr(`HIO_OFS_BYTE_HI, 32'h3c, 4'h1, 2'h0);
    check(out_byte_hi, 8'h3c);
    wr(`HIO_OFS_HALFWORD, 32'h81c3, 4'h3, 2'h0);
    check({out_byte_hi, out_byte_lo}, 16'h81c3);
    wr(`HIO_OFS_CTRL, 32'hc, 4'h1, 2'h0);
    rd(`HIO_OFS_CTRL, 32'hc, 2'h0);
    wr(`HIO_OFS_HALFWORD, 32'h40aa, 4'h3, 2'h0);
    check(out_byte_hi, 8'h00);
    rd(`HIO_OFS_HALFWORD, 32'h80aa, 2'h0);
    sort_index_strobe <= 1'b1;
    repeat (2) @(posedge aclk);
    check(out_byte_hi, 8'h40);
    sort_index_strobe <= 1'b0;
    trigger_ready_flag <= 1'b1;
    repeat (2) @(posedge aclk);
    check(out_byte_hi, 8'h80);
    trigger_ready_flag <= 1'b0;
    wr(`HIO_OFS_BYTE_HI, 32'h7f, 4'h1, 2'h0);
    check(out_byte_hi, 8'h3f);
    // strobes off before using bits 6 and 7
    wr(`HIO_OFS_CTRL, 32'h0, 4'h1, 2'h0);
    check(out_byte_hi, 8'hbf);
    rd(`HIO_OFS_HALFWORD, 32'hbfaa, 2'h0);
    hnd_lo <= 4'h9;
    hnd_hi <= 4'h6;
    repeat (4) @(posedge aclk);
    rd(`HIO_OFS_NIB_LO, 32'h9, 2'h0);
    rd(`HIO_OFS_NIB_HI, 32'h6, 2'h0);
    rd(`HIO_OFS_NIB_BOTH, 32'h69, 2'h0);
    wr(`HIO_OFS_CTRL, 32'h1, 4'h1, 2'h0);
    wr(`HIO_OFS_NIB_LO, 32'h5, 4'h1, 2'h0);
    check({nibble_lo_oe, nibble_lo_out}, 8'hf5);
    rd(`HIO_OFS_NIB_BOTH, 32'h65, 2'h0);
    rd(`HIO_OFS_CTRL, 32'h1, 2'h0);
    wr(`HIO_OFS_CTRL, 32'h3, 4'h1, 2'h0);
    wr(`HIO_OFS_NIB_BOTH, 32'ha3, 4'h1, 2'h0);
    check({nibble_hi_out, nibble_lo_out}, 8'ha3);
    check(nibble_hi_oe, 4'hf);
    rd(`HIO_OFS_NIB_HI, 32'ha, 2'h0);
    wr(`HIO_OFS_CTRL, 32'h0, 4'h1, 2'h0);
    repeat (4) @(posedge aclk);
    rd(`HIO_OFS_NIB_BOTH, 32'h69, 2'h0);
    for (int v = 1; v < 3; v++) begin
      wr(`HIO_OFS_SINGLE, v, 4'h1, 2'h0);
      check({single_out_terminal_two, single_out_terminal_one}, v);
      rd(`HIO_OFS_SINGLE, v, 2'h0);
    end
    // unmapped place: refused, nothing changes
    wr(8'h20, 32'hffff_ffff, 4'hf, 2'h2);
    rd(8'h20, 32'h0, 2'h2);
    check(out_byte_lo, 8'haa);
    stop_test;
  end

  // watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    stop_test;
  end
endmodule
